// ---- hdl/rtcrm_core.sv ----
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`default_nettype none
module rtcrm_core (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [8:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic        busWriteGuard,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq,
   output logic [7:0]       evPeriodic,
   output logic             evOverflow,
   output logic [1:0]       evMatch
);

   typedef struct packed {
      logic                            ack;
      logic [31:0]                     rdData;
      logic [15:0]                     ctrl;
      logic                            running;
      logic [15:0]                     rdReq;
      logic [15:0]                     evCfg;
      logic [7:0]                      mask;
      logic [7:0]                      flags;
      logic [7:0]                      dbg;
      logic [7:0]                      trim;
      logic [31:0]                     count;
      logic [31:0]                     countView;
      logic [31:0]                     pendCount;
      logic [15:0]                     top_limit_16;
      logic [31:0]                     cmp0;
      logic [15:0]                     cmp1;
      logic [7:0]                      depth;
      logic [9:0]                      preCnt;
      rtcrm_pkg::rtcrm_sync_kind_t     kind;
      logic [7:0]                      evPer;
      logic                            evOvf;
      logic [1:0]                      evCmp;
   } rtcrm_core_t;

   localparam rtcrm_core_t CORE_RESET = '0;

   logic        rstnMeta;
   logic        rstnSync;
   rtcrm_core_t s;
   rtcrm_core_t next_s;
   logic        sync_pending;
   logic        syncDone;
   logic        syncStart;
   logic        syncAcc;
   logic        take;
   logic        tick;
   logic [6:0]  idx;
   logic [31:0] bm;
   logic [31:0] wd;
   logic [7:0]  setF;
   logic [7:0]  clrF;
   logic [9:0]  divMask;
   logic [32:0] calNext;
   logic        alarmHit;
   logic        swrstWr;
   rtcrm_pkg::rtcrm_mode_t mode;

   // ==========================================================================
   // Reset release.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstnMeta <= 1'b0;
         rstnSync <= 1'b0;
      end else begin
         rstnMeta <= 1'b1;
         rstnSync <= rstnMeta;
      end
   end

   // ==========================================================================
   // Calendar step; carry out of the year field marks an overflow.
   function automatic logic [32:0] calInc(input logic [31:0] t);
      logic [5:0] sec;
      logic [5:0] min;
      logic [4:0] hr;
      logic [4:0] dy;
      logic [3:0] mo;
      logic [5:0] yr;
      logic       cy;
      sec = t[5:0];
      min = t[11:6];
      hr  = t[16:12];
      dy  = t[21:17];
      mo  = t[25:22];
      yr  = t[31:26];
      cy  = 1'b1;
      if (sec == rtcrm_pkg::SEC_MAX) sec = 6'h00;
      else begin sec = sec + 6'h01; cy = 1'b0; end
      if (cy) begin
         if (min == rtcrm_pkg::SEC_MAX) min = 6'h00;
         else begin min = min + 6'h01; cy = 1'b0; end
      end
      if (cy) begin
         if (hr == rtcrm_pkg::HOUR_MAX) hr = 5'h00;
         else begin hr = hr + 5'h01; cy = 1'b0; end
      end
      if (cy) begin
         if (dy == rtcrm_pkg::DAY_MAX) dy = rtcrm_pkg::DAY_FIRST;
         else begin dy = dy + 5'h01; cy = 1'b0; end
      end
      if (cy) begin
         if (mo == rtcrm_pkg::MON_MAX) mo = rtcrm_pkg::MON_FIRST;
         else begin mo = mo + 4'h1; cy = 1'b0; end
      end
      if (cy) begin
         if (yr == rtcrm_pkg::YEAR_MAX) yr = 6'h00;
         else begin yr = yr + 6'h01; cy = 1'b0; end
      end
      calInc = {cy, yr, mo, dy, hr, min, sec};
   endfunction : calInc

   // ==========================================================================
   // Bus decode.
   assign idx  = wb_adr_i[8:2];
   assign mode = rtcrm_pkg::rtcrm_mode_t'(s.ctrl[rtcrm_pkg::CTL_MODE +: 2]);

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         bm[i*8 +: 8] = {8{wb_sel_i[i]}};
      end
   end

   // Byte-lane merge against the register's current value.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                         input logic [31:0] d);
      merge = (old & ~m) | (d & m);
   endfunction : merge

   assign wd = wb_dat_i;

   always_comb begin
      unique case (idx)
         rtcrm_pkg::IDX_CTRL, rtcrm_pkg::IDX_COUNT, rtcrm_pkg::IDX_PER,
         rtcrm_pkg::IDX_CMP0, rtcrm_pkg::IDX_CMP1, rtcrm_pkg::IDX_TRIM,
         rtcrm_pkg::IDX_DEPTH: syncAcc = wb_we_i;
         rtcrm_pkg::IDX_RDREQ: syncAcc = wb_we_i && wb_sel_i[1] && wd[rtcrm_pkg::RDQ_TRIG];
         default:              syncAcc = 1'b0;
      endcase
   end

   // A synchronized access while busy is held off without an answer.
   assign take    = wb_cyc_i && wb_stb_i && !s.ack && !(syncAcc && sync_pending);
   assign swrstWr = take && wb_we_i && idx == rtcrm_pkg::IDX_CTRL && !busWriteGuard
                    && wb_sel_i[0] && wd[rtcrm_pkg::CTL_SOFT_RESET];

   // ==========================================================================
   // Prescaler tick; reserved codes stop the counter.
   assign divMask = 10'((11'h001 << s.ctrl[rtcrm_pkg::CTL_PRE +: 4]) - 11'h001);
   assign tick = s.running && s.ctrl[rtcrm_pkg::CTL_PRE +: 4] <= rtcrm_pkg::PRE_MAX
                 && (s.preCnt & divMask) == divMask;
   assign calNext  = calInc(s.count);
   assign alarmHit = s.depth[2:0] != 3'h0
                     && ((s.count ^ s.cmp0) & rtcrm_pkg::ALARM_MASK[s.depth[2:0]]) == 32'h0;

   // ==========================================================================
   // Next state.
   always_comb begin
      next_s       = s;
      setF         = 8'h00;
      clrF         = 8'h00;
      syncStart    = 1'b0;
      next_s.ack   = take;
      next_s.evPer = 8'h00;
      next_s.evOvf = 1'b0;
      next_s.evCmp = 2'b00;
      next_s.preCnt = s.running ? s.preCnt + 10'h001 : 10'h000;
      for (int n = 0; n < 8; n++) begin
         next_s.evPer[n] = s.evCfg[n] && s.ctrl[rtcrm_pkg::CTL_PRE +: 4] != 4'h0
                           && next_s.preCnt[n+2] && !s.preCnt[n+2];
      end

      if (tick) begin
         unique case (mode)
            rtcrm_pkg::MODE_COUNT32: begin
               setF[rtcrm_pkg::FLG_CMP0] = s.count == s.cmp0;
               setF[rtcrm_pkg::FLG_OVF]  = s.count == 32'hffffffff;
               next_s.count = (s.count == s.cmp0 && s.ctrl[rtcrm_pkg::CTL_MCLR]) ? 32'h0
                              : s.count + 32'h1;
            end
            rtcrm_pkg::MODE_COUNT16: begin
               setF[rtcrm_pkg::FLG_CMP0] = s.count[15:0] == s.cmp0[15:0];
               setF[rtcrm_pkg::FLG_CMP1] = s.count[15:0] == s.cmp1;
               setF[rtcrm_pkg::FLG_OVF]  = s.count[15:0] == s.top_limit_16;
               next_s.count = {16'h0000, (s.count[15:0] == s.top_limit_16) ? 16'h0000
                               : s.count[15:0] + 16'h0001};
            end
            rtcrm_pkg::MODE_CALENDAR: begin
               setF[rtcrm_pkg::FLG_CMP0] = alarmHit;
               setF[rtcrm_pkg::FLG_OVF]  = calNext[32];
               next_s.count = (alarmHit && s.ctrl[rtcrm_pkg::CTL_MCLR]) ? 32'h0
                              : calNext[31:0];
            end
            rtcrm_pkg::MODE_RSVD: begin
               next_s.count = s.count;
            end
         endcase
         next_s.evCmp = setF[1:0] & s.evCfg[rtcrm_pkg::EVC_CMP0 +: 2];
         next_s.evOvf = setF[rtcrm_pkg::FLG_OVF] && s.evCfg[rtcrm_pkg::EVC_OVF];
      end
      if (s.rdReq[rtcrm_pkg::RDQ_CONT]) begin
         next_s.countView = s.count;
      end

      // Register writes; reads are answered from the state before this edge.
      if (take && wb_we_i) begin
         unique case (idx)
            rtcrm_pkg::IDX_CTRL: begin
               if (swrstWr) begin
                  next_s.ctrl[rtcrm_pkg::CTL_SOFT_RESET] = 1'b1;
                  next_s.kind = rtcrm_pkg::SK_RESET;
                  syncStart   = 1'b1;
               end else if (!busWriteGuard) begin
                  if (!s.ctrl[rtcrm_pkg::CTL_EN] && !s.running) begin
                     next_s.ctrl = 16'(merge({16'h0, s.ctrl},
                        {16'h0, bm[15:0] & rtcrm_pkg::CTRL_PROT}, wd));
                  end
                  if (wb_sel_i[0]) begin
                     next_s.ctrl[rtcrm_pkg::CTL_EN] = wd[rtcrm_pkg::CTL_EN];
                     next_s.kind = rtcrm_pkg::SK_CTRL;
                     syncStart   = 1'b1;
                  end
               end
            end
            rtcrm_pkg::IDX_RDREQ: begin
               next_s.rdReq = 16'(merge({16'h0, s.rdReq}, bm, wd)) & rtcrm_pkg::RDREQ_MASK;
               if (syncAcc) begin
                  next_s.kind = rtcrm_pkg::SK_READ;
                  syncStart   = 1'b1;
               end
            end
            rtcrm_pkg::IDX_EVCFG: next_s.evCfg = 16'(merge({16'h0, s.evCfg}, bm, wd))
                                                 & rtcrm_pkg::EVCFG_MASK;
            rtcrm_pkg::IDX_MCLR: if (wb_sel_i[0]) next_s.mask = s.mask & ~wd[7:0];
            rtcrm_pkg::IDX_MSET: if (wb_sel_i[0]) next_s.mask = (s.mask | wd[7:0])
                                                                & rtcrm_pkg::FLAG_MASK;
            rtcrm_pkg::IDX_FLAGS: if (wb_sel_i[0]) clrF = wd[7:0];
            rtcrm_pkg::IDX_DBG: if (wb_sel_i[0]) next_s.dbg = wd[7:0] & rtcrm_pkg::DBG_MASK;
            rtcrm_pkg::IDX_COUNT: begin
               next_s.pendCount = merge(s.count, bm, wd);
               next_s.kind = rtcrm_pkg::SK_COUNT;
               syncStart   = 1'b1;
            end
            default: begin
               if (idx == rtcrm_pkg::IDX_PER) next_s.top_limit_16 = 16'(merge({16'h0, s.top_limit_16}, bm, wd));
               if (idx == rtcrm_pkg::IDX_CMP0) next_s.cmp0 = merge(s.cmp0, bm, wd);
               if (idx == rtcrm_pkg::IDX_CMP1) next_s.cmp1 = 16'(merge({16'h0, s.cmp1}, bm, wd));
               if (idx == rtcrm_pkg::IDX_TRIM && wb_sel_i[0]) next_s.trim = wd[7:0];
               if (idx == rtcrm_pkg::IDX_DEPTH && wb_sel_i[0]) begin
                  next_s.depth = wd[7:0] & rtcrm_pkg::DEPTH_MASK;
               end
               if (syncAcc) begin
                  next_s.kind = rtcrm_pkg::SK_OTHER;
                  syncStart   = 1'b1;
               end
            end
         endcase
      end

      // Read data is registered so it lines up with the acknowledge.
      next_s.rdData = 32'h0;
      if (take && !wb_we_i) begin
         unique case (idx)
            rtcrm_pkg::IDX_CTRL:  next_s.rdData = {16'h0, s.ctrl};
            rtcrm_pkg::IDX_RDREQ: next_s.rdData = {16'h0, s.rdReq};
            rtcrm_pkg::IDX_EVCFG: next_s.rdData = {16'h0, s.evCfg};
            rtcrm_pkg::IDX_MCLR, rtcrm_pkg::IDX_MSET: next_s.rdData = {24'h0, s.mask};
            rtcrm_pkg::IDX_FLAGS: next_s.rdData = {24'h0, s.flags};
            rtcrm_pkg::IDX_SYNC:  next_s.rdData = {24'h0, sync_pending, 7'h00};
            rtcrm_pkg::IDX_DBG:   next_s.rdData = {24'h0, s.dbg};
            rtcrm_pkg::IDX_TRIM:  next_s.rdData = {24'h0, s.trim};
            rtcrm_pkg::IDX_COUNT: next_s.rdData = (mode == rtcrm_pkg::MODE_COUNT16)
                                  ? {16'h0, s.countView[15:0]} : s.countView;
            rtcrm_pkg::IDX_PER:   next_s.rdData = {16'h0, s.top_limit_16};
            rtcrm_pkg::IDX_CMP0:  next_s.rdData = (mode == rtcrm_pkg::MODE_COUNT16)
                                  ? {16'h0, s.cmp0[15:0]} : s.cmp0;
            rtcrm_pkg::IDX_CMP1:  next_s.rdData = {16'h0, s.cmp1};
            rtcrm_pkg::IDX_DEPTH: next_s.rdData = {24'h0, s.depth};
            default:              next_s.rdData = 32'h0;
         endcase
      end

      // Completion of a crossing.
      if (syncDone) begin
         unique case (s.kind)
            rtcrm_pkg::SK_CTRL:  next_s.running = s.ctrl[rtcrm_pkg::CTL_EN];
            rtcrm_pkg::SK_COUNT: next_s.count = s.pendCount;
            rtcrm_pkg::SK_READ: begin
               next_s.countView = s.count;
               next_s.rdReq[rtcrm_pkg::RDQ_TRIG] = 1'b0;
            end
            default: ;
         endcase
         setF[rtcrm_pkg::FLG_SYNC] = s.kind != rtcrm_pkg::SK_RESET;
         next_s.kind = rtcrm_pkg::SK_IDLE;
      end

      // A flag raised in the cycle of its clear stays set.
      next_s.flags = ((s.flags & ~clrF) | setF) & rtcrm_pkg::FLAG_MASK;

      if (syncDone && s.kind == rtcrm_pkg::SK_RESET) begin
         next_s      = CORE_RESET;
         next_s.dbg  = s.dbg;
         next_s.ack  = take;
      end
   end

   always_ff @(posedge sys_clk or negedge rstnSync) begin
      if (!rstnSync) begin
         s <= CORE_RESET;
      end else begin
         s <= next_s;
      end
   end

   rtcrm_sync_timer u_sync (
      .sys_clk  (sys_clk),
      .rstnSync (rstnSync),
      .start    (syncStart),
      .busy     (sync_pending),
      .done     (syncDone)
   );

   assign wb_ack_o   = s.ack;
   assign wb_dat_o   = s.rdData;
   assign irq        = |(s.flags & s.mask);
   assign evPeriodic = s.evPer;
   assign evOverflow = s.evOvf;
   assign evMatch    = s.evCmp;

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstnSync);

   sequence seqCtrlWrite;
      take && wb_we_i && idx == rtcrm_pkg::IDX_CTRL;
   endsequence

   sequence seqResetRun;
      s.ctrl[rtcrm_pkg::CTL_SOFT_RESET] && sync_pending;
   endsequence

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held for more than one cycle");
   a_byte_lane: assert property (take && wb_we_i && idx == rtcrm_pkg::IDX_PER && wb_sel_i == 4'h1
      |=> $stable(s.top_limit_16[15:8]))
      else $error("byte write touched the other byte");
   a_enable_guard: assert property (seqCtrlWrite ##0 (s.running && !busWriteGuard && !swrstWr)
      |=> $stable(s.ctrl[11:2]))
      else $error("protected control field changed while running");
   a_write_guard: assert property (seqCtrlWrite ##0 busWriteGuard |=> $stable(s.ctrl))
      else $error("guarded control write took effect");
   a_sync_stall: assert property (wb_cyc_i && wb_stb_i && syncAcc && sync_pending |=> !wb_ack_o)
      else $error("synchronized access answered while busy");
   a_busy_set: assert property (syncStart |=> sync_pending [*4] ##1 !sync_pending)
      else $error("busy not set at once after a synchronized access");
   a_soft_reset_clear: assert property (swrstWr |=> seqResetRun [*4] ##1 (s.ctrl == 16'h0000
      && !sync_pending && !s.running))
      else $error("soft reset did not finish with a cleared control word");
   a_mode_rsvd: assert property (tick && mode == rtcrm_pkg::MODE_RSVD && !syncDone
      |=> $stable(s.count))
      else $error("counter moved in the reserved mode");
   a_pre_rsvd: assert property (s.ctrl[11:8] > rtcrm_pkg::PRE_MAX |-> !tick)
      else $error("reserved prescaler code produced a tick");

endmodule : rtcrm_core
`default_nettype wire

// ---- hdl/rtcrm_pkg.sv ----
package rtcrm_pkg;

   // ==========================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int SYNC_TIME_NS  = 400;
   localparam int SYNC_LAT      = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam logic [6:0] IDX_CTRL  = 7'h00;
   localparam logic [6:0] IDX_RDREQ = 7'h02;
   localparam logic [6:0] IDX_EVCFG = 7'h04;
   localparam logic [6:0] IDX_MCLR  = 7'h06;
   localparam logic [6:0] IDX_MSET  = 7'h07;
   localparam logic [6:0] IDX_FLAGS = 7'h08;
   localparam logic [6:0] IDX_SYNC  = 7'h0a;
   localparam logic [6:0] IDX_DBG   = 7'h0b;
   localparam logic [6:0] IDX_TRIM  = 7'h0c;
   localparam logic [6:0] IDX_COUNT = 7'h10;
   localparam logic [6:0] IDX_PER   = 7'h14;
   localparam logic [6:0] IDX_CMP0  = 7'h18;
   localparam logic [6:0] IDX_CMP1  = 7'h1a;
   localparam logic [6:0] IDX_DEPTH = 7'h1c;

   // ==========================================================================
   // Fields and reset values
   localparam int CTL_SOFT_RESET   = 0;
   localparam int CTL_EN      = 1;
   localparam int CTL_MODE    = 2;
   localparam int CTL_MCLR    = 7;
   localparam int CTL_PRE     = 8;
   localparam int RDQ_CONT    = 14;
   localparam int RDQ_TRIG    = 15;
   localparam int EVC_CMP0    = 8;
   localparam int EVC_OVF     = 15;
   localparam int FLG_CMP0    = 0;
   localparam int FLG_CMP1    = 1;
   localparam int FLG_SYNC    = 6;
   localparam int FLG_OVF     = 7;
   localparam int STAT_BUSY   = 7;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_PROT  = 16'h0fcc;
   localparam logic [15:0] RDREQ_MASK = 16'hc03f;
   localparam logic [15:0] EVCFG_MASK = 16'h83ff;
   localparam logic [7:0]  FLAG_MASK  = 8'hc3;
   localparam logic [7:0]  DBG_MASK   = 8'h01;
   localparam logic [7:0]  DEPTH_MASK = 8'h07;
   localparam logic [3:0]  PRE_MAX    = 4'ha;

   // Calendar limits.
   localparam logic [5:0] SEC_MAX   = 6'h3b;
   localparam logic [4:0] HOUR_MAX  = 5'h17;
   localparam logic [4:0] DAY_MAX   = 5'h1f;
   localparam logic [4:0] DAY_FIRST = 5'h01;
   localparam logic [3:0] MON_MAX   = 4'hc;
   localparam logic [3:0] MON_FIRST = 4'h1;
   localparam logic [5:0] YEAR_MAX  = 6'h3f;
   localparam logic [31:0] ALARM_MASK [0:7] = '{32'h00000000, 32'h0000003f, 32'h00000fff,
      32'h0001ffff, 32'h003fffff, 32'h03ffffff, 32'hffffffff, 32'h00000000};

   typedef enum logic [1:0] {
      MODE_COUNT32  = 2'h0,
      MODE_COUNT16  = 2'h1,
      MODE_CALENDAR = 2'h2,
      MODE_RSVD     = 2'h3
   } rtcrm_mode_t;

   typedef enum logic [2:0] {
      SK_IDLE  = 3'h0,
      SK_CTRL  = 3'h1,
      SK_COUNT = 3'h3,
      SK_READ  = 3'h2,
      SK_OTHER = 3'h6,
      SK_RESET = 3'h7
   } rtcrm_sync_kind_t;

endpackage : rtcrm_pkg

// ---- hdl/rtcrm_sync_timer.sv ----
`timescale 1ns/1ns
`default_nettype none
module rtcrm_sync_timer (
   input  wire logic sys_clk,
   input  wire logic rstnSync,
   input  wire logic start,
   output logic      busy,
   output logic      done
);

   typedef struct packed {
      logic [3:0] left;
   } rtcrm_timer_t;

   rtcrm_timer_t s;
   rtcrm_timer_t next_s;

   // ==========================================================================
   // Latency of the crossing into the counter domain.
   always_comb begin
      next_s = s;
      if (start && s.left == 4'h0) begin
         next_s.left = 4'(rtcrm_pkg::SYNC_LAT);
      end else if (s.left != 4'h0) begin
         next_s.left = s.left - 4'h1;
      end
   end

   always_ff @(posedge sys_clk or negedge rstnSync) begin
      if (!rstnSync) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign busy = s.left != 4'h0;
   assign done = s.left == 4'h1;

   a_sync_length: assert property (@(posedge sys_clk) disable iff (!rstnSync)
      start && !busy |=> busy [*4] ##1 !busy)
      else $error("sync busy window has the wrong length");

endmodule : rtcrm_sync_timer
`default_nettype wire

// ---- verification/rtc_register_map_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module rtc_register_map_test;
   logic        sys_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        wbCyc   = 1'b0;
   logic        wbStb   = 1'b0;
   logic        wbWe    = 1'b0;
   logic [8:0]  wbAdr   = 9'h000;
   logic [3:0]  wbSel   = 4'h0;
   logic [31:0] wbDatW  = 32'h00000000;
   logic        guard   = 1'b0;
   logic [31:0] wbDatR;
   logic        wbAck;
   logic        irq;
   logic [7:0]  evPer;
   logic        evOvf;
   logic [1:0]  evCmp;
   logic [31:0] q;
   int          errors      = 0;
   int          comparisons = 0;

   rtcrm_core i_rtcrm_core (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
      .busWriteGuard(guard), .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .irq(irq),
      .evPeriodic(evPer), .evOverflow(evOvf), .evMatch(evCmp));

   initial begin
      forever #50 sys_clk = ~sys_clk;
   end

   // ==========================================================================
   // Bus access
   // Ack is sampled at each rising edge; the request is released at the edge
   // that saw it high, and a stalled access simply waits longer.
   task automatic xfer(input logic we, input logic [6:0] idx, input logic [3:0] sel,
                       input logic [31:0] d, output logic [31:0] r);
      int n = 0;
      @(posedge sys_clk);
      wbCyc  <= 1'b1;
      wbStb  <= 1'b1;
      wbWe   <= we;
      wbAdr  <= {idx, 2'b00};
      wbSel  <= sel;
      wbDatW <= d;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 50);
      if (wbAck !== 1'b1) begin
         errors++;
         $display("ERROR %0t: no ack", $time);
      end
      r = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [6:0] idx, input logic [3:0] sel, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, idx, sel, d, r);
   endtask : wr

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdchk(input logic [6:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 4'hf, 32'h0, q);
      chk(q, exp);
   endtask : rdchk

   task automatic irqchk(input logic exp);
      @(negedge sys_clk);
      chk({31'h0, irq}, {31'h0, exp});
   endtask : irqchk

   // Event outputs are one-cycle pulses, so every rising edge is looked at.
   task automatic evchk(input int which);
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 64 && !seen; n++) begin
         @(posedge sys_clk);
         seen = (which == 0) ? evPer[0] : (which == 1) ? evOvf : evCmp[0];
      end
      chk({31'h0, seen}, 32'h00000001);
   endtask : evchk

   task automatic end_sim;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_sim

   // ==========================================================================
   // Tests
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rdchk(rtcrm_pkg::IDX_CTRL, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(rtcrm_pkg::IDX_CTRL, 4'h1, 32'(m << 2));
         rdchk(rtcrm_pkg::IDX_CTRL, 32'(m << 2));
      end
      $display("test modes done");
      wr(rtcrm_pkg::IDX_CTRL, 4'h1, 32'h0000000a);
      rdchk(rtcrm_pkg::IDX_SYNC, 32'h80);
      wr(rtcrm_pkg::IDX_CTRL, 4'h3, 32'h00000a06);
      rdchk(rtcrm_pkg::IDX_CTRL, 32'h0000000a);
      xfer(1'b0, rtcrm_pkg::IDX_FLAGS, 4'hf, 32'h0, q);
      chk(q & 32'h40, 32'h40);
      $display("test enable and sync done");
      wr(rtcrm_pkg::IDX_MSET, 4'h1, 32'h40);
      irqchk(1'b1);
      wr(rtcrm_pkg::IDX_MCLR, 4'h1, 32'h40);
      irqchk(1'b0);
      wr(rtcrm_pkg::IDX_MSET, 4'h1, 32'h40);
      wr(rtcrm_pkg::IDX_FLAGS, 4'h1, 32'h40);
      irqchk(1'b0);
      $display("test interrupt done");
      @(posedge sys_clk);
      guard <= 1'b1;
      wr(rtcrm_pkg::IDX_CTRL, 4'h3, 32'h0);
      rdchk(rtcrm_pkg::IDX_CTRL, 32'h0000000a);
      @(posedge sys_clk);
      guard <= 1'b0;
      wr(rtcrm_pkg::IDX_CTRL, 4'h3, 32'h0);
      rdchk(rtcrm_pkg::IDX_CTRL, 32'h00000008);
      $display("test guard done");
      wr(rtcrm_pkg::IDX_PER, 4'h1, 32'h000000ff);
      wr(rtcrm_pkg::IDX_PER, 4'h2, 32'h00001200);
      rdchk(rtcrm_pkg::IDX_PER, 32'h000012ff);
      wr(7'h09, 4'hf, 32'hffffffff);
      rdchk(7'h09, 32'h0);
      $display("test sub-word done");
      wr(rtcrm_pkg::IDX_DBG, 4'h1, 32'h1);
      wr(rtcrm_pkg::IDX_CTRL, 4'h1, 32'h0000000b);
      for (int n = 0; n < 10; n++) begin
         xfer(1'b0, rtcrm_pkg::IDX_SYNC, 4'hf, 32'h0, q);
         if (q[7] === 1'b0)
            break;
      end
      rdchk(rtcrm_pkg::IDX_CTRL, 32'h0);
      rdchk(rtcrm_pkg::IDX_PER, 32'h0);
      rdchk(rtcrm_pkg::IDX_SYNC, 32'h0);
      rdchk(rtcrm_pkg::IDX_DBG, 32'h1);
      $display("test soft reset done");
      wr(rtcrm_pkg::IDX_EVCFG, 4'h3, 32'h00008101);
      wr(rtcrm_pkg::IDX_COUNT, 4'hf, 32'hfffffff0);
      wr(rtcrm_pkg::IDX_CTRL, 4'h3, 32'h00000102);
      evchk(0);
      evchk(1);
      evchk(2);
      $display("test events done");
      wr(rtcrm_pkg::IDX_CTRL, 4'h1, 32'h00000000);
      wr(rtcrm_pkg::IDX_CTRL, 4'h1, 32'h0000000e);
      wr(rtcrm_pkg::IDX_COUNT, 4'hf, 32'h00001234);
      wr(rtcrm_pkg::IDX_RDREQ, 4'h2, 32'h00008000);
      rdchk(rtcrm_pkg::IDX_SYNC, 32'h80);
      rdchk(rtcrm_pkg::IDX_COUNT, 32'h00001234);
      $display("test reserved mode done");
      end_sim();
   end

   // A stalled access gives up in xfer after 50 cycles; any other hang ends here instead of running forever.
   initial begin
      #400000;
      errors++;
      end_sim();
   end
endmodule : rtc_register_map_test
`default_nettype wire
